// ---- tlp_ordering_ecrc_defines.vh ----
// Shared offsets, field positions, reset values and encodings for the TLP ordering and ECRC path
`ifndef TLP_ORDERING_ECRC_DEFINES_VH
`define TLP_ORDERING_ECRC_DEFINES_VH

// Register byte addresses
`define REG_CTRL_ADDR        8'h00
`define REG_STATUS_ADDR      8'h04
`define REG_ERR_COUNT_ADDR   8'h08

// Control register fields and reset value
`define CTRL_CHECK_EN_BIT    0
`define CTRL_GEN_EN_BIT      1
`define CTRL_FWD_EN_BIT      2
`define CTRL_LFC_EN_BIT      3
`define CTRL_WIDTH           4
`define CTRL_RESET           4'h0

// Status register fields
`define STAT_STAGE_LSB       0
`define STAT_STAGE_MSB       3
`define STAT_LFC_OFFERED_BIT 4
`define STAT_ERR_SEEN_BIT    5

// Compact TLP header word fields
`define HDR_CLASS_LSB        0
`define HDR_CLASS_MSB        1
`define HDR_RO_BIT           2
`define HDR_DIGEST_BIT       3
`define HDR_CFG0_BIT         4
`define HDR_MSI_BIT          5

// Traffic classes
`define CLS_POSTED           2'h0
`define CLS_NONPOSTED        2'h1
`define CLS_COMPLETION       2'h2

// Link rate codes
`define RATE_GEN1            2'h1
`define RATE_GEN2            2'h2

// Receive queue geometry
`define QUEUE_DEPTH          3'h4
`define STAMP_WIDTH          5

// ECRC polynomial and seed
`define CRC_POLY             32'h04c11db7
`define CRC_SEED             32'hffffffff

// Configuration staging states, one-hot
`define STG_WAIT_PERIPH      4'h1
`define STG_TRAIN            4'h2
`define STG_LINK_CFG         4'h4
`define STG_CORE_READY       4'h8

`endif

// ---- tlp_ordering_ecrc_path.v ----
// TLP receive ordering, ECRC check/strip/forward and transmit ECRC generation
// Overview of operation
// - Posted TLPs with relaxed order clear never pass earlier posted TLPs.
// - Posted TLPs with relaxed order set also never pass earlier posted TLPs.
// - Posted TLPs can always pass queued completions, avoiding deadlock.
// - Completion waits behind every queued posted TLP, even with its relaxed order bit set.
// - Completions of different requests are never reordered against each other.
// - Completions of one request leave in arrival, thus address, order.
// - Non-posted requests never pass other non-posted requests.
// - Type-0 config reads may pass reads; we keep strict order instead.
// - Type-0 config writes may pass I/O writes; strict order kept.
// - When app is full of non-posted, posted and completions bypass them; four queued non-posted block all receive input.
// - While hold input is high, non-posted TLPs are withheld from delivery.
// - MSI writes are handled exactly as ordinary posted memory writes.
// - Link-first flow: periphery loads, link reaches L0, then carries core config.
// - Link-first configuration offered only at first and second generation rates.
// - Check on: bad ECRC raises error and TLP is dropped.
// - Check off: bad ECRC raises no error and TLP is delivered.
// - Forwarding on keeps received ECRC attached; off strips it.
// - Digest flag set means an ECRC is appended to the TLP; receive keeps the flag set when forwarding off strips the ECRC.
// - Transmit, forwarding off: generate and set flag, or clear flag, no ECRC.
// - Transmit, forwarding on: application TLP sent unchanged.
`include "tlp_ordering_ecrc_defines.vh"
`default_nettype none

module tlp_ordering_ecrc_path (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst_n,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // Receive TLPs from the link
  input  wire        rx_in_valid,
  input  wire [31:0] rx_in_hdr,
  input  wire [31:0] rx_in_data,
  input  wire [31:0] rx_in_ecrc,
  output reg         rx_in_ready,
  // Receive TLPs to the application
  output reg         rx_out_valid,
  output reg  [31:0] rx_out_hdr,
  output reg  [31:0] rx_out_data,
  output reg  [31:0] rx_out_ecrc,
  output reg         rx_out_ecrc_valid,
  input  wire        rx_out_ready,
  input  wire        rx_np_hold,
  output reg         rx_ecrc_error,
  // Transmit TLPs from the application
  input  wire        tx_in_valid,
  input  wire [31:0] tx_in_hdr,
  input  wire [31:0] tx_in_data,
  input  wire [31:0] tx_in_ecrc,
  output reg         tx_in_ready,
  // Transmit TLPs to the link
  output reg         tx_out_valid,
  output reg  [31:0] tx_out_hdr,
  output reg  [31:0] tx_out_data,
  output reg  [31:0] tx_out_ecrc,
  input  wire        tx_out_ready,
  // Configuration staging
  input  wire        periph_loaded,
  input  wire        link_l0,
  input  wire [1:0]  link_rate,
  input  wire        core_programmed,
  output reg         core_cfg_over_link,
  output reg         core_ready
);

  localparam ENT_W = 32 + 32 + 32 + 1 + `STAMP_WIDTH;

  // CRC-32 over header and data words
  function [31:0] crc64;
    input [63:0] d;
    integer i;
    reg [31:0] c;
    begin
      c = `CRC_SEED;
      for (i = 63; i >= 0; i = i - 1) begin
        if (c[31] ^ d[i]) begin
          c = {c[30:0], 1'b0} ^ `CRC_POLY;
        end else begin
          c = {c[30:0], 1'b0};
        end
      end
      crc64 = ~c;
    end
  endfunction

  // True when stamp a was taken before stamp b
  function older;
    input [`STAMP_WIDTH-1:0] a;
    input [`STAMP_WIDTH-1:0] b;
    reg [`STAMP_WIDTH-1:0] diff;
    begin
      diff = a - b;
      older = diff[`STAMP_WIDTH-1];
    end
  endfunction

  // Class decode, unknown codes join posted traffic
  function [1:0] class_of;
    input [31:0] hdr;
    begin
      if (hdr[`HDR_CLASS_MSB:`HDR_CLASS_LSB] == `CLS_NONPOSTED) begin
        class_of = `CLS_NONPOSTED;
      end else if (hdr[`HDR_CLASS_MSB:`HDR_CLASS_LSB] == `CLS_COMPLETION) begin
        class_of = `CLS_COMPLETION;
      end else begin
        class_of = `CLS_POSTED;
      end
    end
  endfunction

  // Control and status state
  reg [`CTRL_WIDTH-1:0]  ctrl_q;
  reg [15:0]             err_count_q;
  reg                    err_seen_q;
  reg [3:0]              stage_q;
  reg [3:0]              stage_d;

  wire check_en = ctrl_q[`CTRL_CHECK_EN_BIT];
  wire gen_en   = ctrl_q[`CTRL_GEN_EN_BIT];
  wire fwd_en   = ctrl_q[`CTRL_FWD_EN_BIT];
  wire lfc_en   = ctrl_q[`CTRL_LFC_EN_BIT];
  wire lfc_offered = lfc_en && ((link_rate == `RATE_GEN1) || (link_rate == `RATE_GEN2));

  // Receive queues, one region of four entries per class
  reg [ENT_W-1:0]        qmem [0:11];
  reg [5:0]              wr_ptr_q;
  reg [5:0]              rd_ptr_q;
  reg [8:0]              cnt_q;
  reg [8:0]              cnt_d;
  reg [`STAMP_WIDTH-1:0] stamp_q;

  // Receive check
  wire        rx_take   = rx_in_valid && rx_in_ready;
  wire        rx_digest = rx_in_hdr[`HDR_DIGEST_BIT];
  wire        rx_crc_ok = (crc64({rx_in_hdr, rx_in_data}) == rx_in_ecrc);
  wire        rx_bad    = rx_digest && !rx_crc_ok;
  wire        rx_drop   = rx_bad && check_en;
  wire        rx_push   = rx_take && !rx_drop;
  wire [1:0]  rx_cls    = class_of(rx_in_hdr);
  wire        keep_ecrc = rx_digest && fwd_en;

  // Queue heads
  wire [ENT_W-1:0]        head [0:2];
  wire [2:0]              head_v;
  wire [`STAMP_WIDTH-1:0] head_stamp [0:2];
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_head
      assign head[g]       = qmem[g * 4 + rd_ptr_q[g*2 +: 2]];
      assign head_v[g]     = (cnt_q[g*3 +: 3] != 3'h0);
      assign head_stamp[g] = head[g][`STAMP_WIDTH-1:0];
    end
  endgenerate

  wire [31:0] cpl_hdr = head[2][ENT_W-1 -: 32];

  // Posted head goes first: posted FIFO order, free pass over others
  wire pick_p = head_v[0];
  // Completion waits behind any posted head, relaxed or not, as the posted pick wins first
  wire pick_c = head_v[2] && (!head_v[0] || cpl_hdr[`HDR_RO_BIT] ||
                older(head_stamp[2], head_stamp[0]));
  // Non-posted waits for hold release and anything older
  wire pick_n = head_v[1] && !rx_np_hold &&
                (!head_v[0] || older(head_stamp[1], head_stamp[0])) &&
                (!head_v[2] || older(head_stamp[1], head_stamp[2]));

  wire out_free = !rx_out_valid || rx_out_ready;
  reg  [1:0] sel_cls;
  reg        sel_v;
  always @* begin
    sel_v   = 1'b0;
    sel_cls = `CLS_POSTED;
    if (out_free) begin
      if (pick_p) begin
        sel_v   = 1'b1;
        sel_cls = `CLS_POSTED;
      end else if (pick_c) begin
        sel_v   = 1'b1;
        sel_cls = `CLS_COMPLETION;
      end else if (pick_n) begin
        sel_v   = 1'b1;
        sel_cls = `CLS_NONPOSTED;
      end
    end
  end

  wire [ENT_W-1:0] sel_ent = head[sel_cls];

  // Queue occupancy next values
  integer k;
  always @* begin
    cnt_d = cnt_q;
    for (k = 0; k < 3; k = k + 1) begin
      if (rx_push && (rx_cls == k[1:0]) && !(sel_v && (sel_cls == k[1:0]))) begin
        cnt_d[k*3 +: 3] = cnt_q[k*3 +: 3] + 3'h1;
      end else if (!(rx_push && (rx_cls == k[1:0])) && sel_v && (sel_cls == k[1:0])) begin
        cnt_d[k*3 +: 3] = cnt_q[k*3 +: 3] - 3'h1;
      end
    end
  end

  // Queue storage and pointers
  always @(posedge core_clk) begin
    if (!rst_n) begin
      wr_ptr_q <= 6'h00;
      rd_ptr_q <= 6'h00;
      cnt_q    <= 9'h000;
      stamp_q  <= {`STAMP_WIDTH{1'b0}};
    end else begin
      cnt_q <= cnt_d;
      if (rx_push) begin
        qmem[rx_cls * 4 + wr_ptr_q[rx_cls*2 +: 2]] <=
          {rx_in_hdr, rx_in_data, keep_ecrc ? rx_in_ecrc : 32'h00000000, keep_ecrc, stamp_q};
        wr_ptr_q[rx_cls*2 +: 2] <= wr_ptr_q[rx_cls*2 +: 2] + 2'h1;
        stamp_q <= stamp_q + {{(`STAMP_WIDTH-1){1'b0}}, 1'b1};
      end
      if (sel_v) begin
        rd_ptr_q[sel_cls*2 +: 2] <= rd_ptr_q[sel_cls*2 +: 2] + 2'h1;
      end
    end
  end

  // Receive input ready, room in every class, one beat per two cycles
  always @(posedge core_clk) begin
    if (!rst_n) begin
      rx_in_ready <= 1'b0;
    end else begin
      rx_in_ready <= (cnt_d[2:0] < `QUEUE_DEPTH) && (cnt_d[5:3] < `QUEUE_DEPTH) &&
                     (cnt_d[8:6] < `QUEUE_DEPTH) && !rx_take;
    end
  end

  // Receive output stage
  always @(posedge core_clk) begin
    if (!rst_n) begin
      rx_out_valid      <= 1'b0;
      rx_out_hdr        <= 32'h00000000;
      rx_out_data       <= 32'h00000000;
      rx_out_ecrc       <= 32'h00000000;
      rx_out_ecrc_valid <= 1'b0;
    end else if (out_free) begin
      rx_out_valid <= sel_v;
      if (sel_v) begin
        rx_out_hdr        <= sel_ent[ENT_W-1 -: 32];
        rx_out_data       <= sel_ent[ENT_W-33 -: 32];
        rx_out_ecrc       <= sel_ent[ENT_W-65 -: 32];
        rx_out_ecrc_valid <= sel_ent[`STAMP_WIDTH];
      end
    end
  end

  // Error pulse, sticky flag and counter
  always @(posedge core_clk) begin
    if (!rst_n) begin
      rx_ecrc_error <= 1'b0;
      err_seen_q    <= 1'b0;
      err_count_q   <= 16'h0000;
    end else begin
      rx_ecrc_error <= rx_take && rx_drop;
      if (rx_take && rx_drop) begin
        err_seen_q <= 1'b1;
        if (err_count_q != 16'hffff) begin
          err_count_q <= err_count_q + 16'h0001;
        end
      end else if (reg_wr && (reg_addr == `REG_ERR_COUNT_ADDR)) begin
        err_seen_q  <= 1'b0;
        err_count_q <= 16'h0000;
      end
    end
  end

  // Transmit path
  wire        tx_take  = tx_in_valid && tx_in_ready;
  wire [31:0] tx_hdr_g = tx_in_hdr | (32'h00000001 << `HDR_DIGEST_BIT);
  wire [31:0] tx_hdr_n = tx_in_hdr & ~(32'h00000001 << `HDR_DIGEST_BIT);
  wire        tx_hold  = tx_out_valid && !tx_out_ready;
  always @(posedge core_clk) begin
    if (!rst_n) begin
      tx_out_valid <= 1'b0;
      tx_out_hdr   <= 32'h00000000;
      tx_out_data  <= 32'h00000000;
      tx_out_ecrc  <= 32'h00000000;
      tx_in_ready  <= 1'b0;
    end else begin
      tx_in_ready <= !(tx_take || tx_hold);
      if (tx_take) begin
        tx_out_valid <= 1'b1;
        tx_out_data  <= tx_in_data;
        if (fwd_en) begin
          tx_out_hdr  <= tx_in_hdr;
          tx_out_ecrc <= tx_in_ecrc;
        end else if (gen_en) begin
          tx_out_hdr  <= tx_hdr_g;
          tx_out_ecrc <= crc64({tx_hdr_g, tx_in_data});
        end else begin
          tx_out_hdr  <= tx_hdr_n;
          tx_out_ecrc <= 32'h00000000;
        end
      end else if (!tx_hold) begin
        tx_out_valid <= 1'b0;
      end
    end
  end

  // Configuration staging
  always @* begin
    stage_d = stage_q;
    case (stage_q)
      `STG_WAIT_PERIPH: begin
        if (periph_loaded) begin
          stage_d = lfc_offered ? `STG_TRAIN : `STG_LINK_CFG;
        end
      end
      `STG_TRAIN: begin
        if (link_l0) begin
          stage_d = `STG_LINK_CFG;
        end
      end
      `STG_LINK_CFG: begin
        if (core_programmed) begin
          stage_d = `STG_CORE_READY;
        end
      end
      `STG_CORE_READY: begin
        stage_d = `STG_CORE_READY;
      end
      default: begin
        stage_d = `STG_WAIT_PERIPH;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      stage_q            <= `STG_WAIT_PERIPH;
      core_cfg_over_link <= 1'b0;
      core_ready         <= 1'b0;
    end else begin
      stage_q            <= stage_d;
      core_cfg_over_link <= (stage_d == `STG_LINK_CFG) && lfc_offered && link_l0;
      core_ready         <= (stage_d == `STG_CORE_READY);
    end
  end

  // Register port
  always @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_q    <= `CTRL_RESET;
      reg_rdata <= 32'h00000000;
    end else begin
      if (reg_wr && (reg_addr == `REG_CTRL_ADDR)) begin
        ctrl_q <= reg_wdata[`CTRL_WIDTH-1:0];
      end
      reg_rdata <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          `REG_CTRL_ADDR: begin
            reg_rdata <= {28'h0000000, ctrl_q};
          end
          `REG_STATUS_ADDR: begin
            reg_rdata <= {26'h0000000, err_seen_q, lfc_offered, stage_q};
          end
          `REG_ERR_COUNT_ADDR: begin
            reg_rdata <= {16'h0000, err_count_q};
          end
          default: begin
            reg_rdata <= 32'h00000000;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ---- tlp_ordering_ecrc_path_props.sv ----
// Concurrent checks on the TLP ordering and ECRC path ports
`default_nettype none
module tlp_ordering_ecrc_path_props (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // Register writes
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  // Receive side
  input wire logic        rx_in_valid,
  input wire logic [31:0] rx_in_hdr,
  input wire logic        rx_in_ready,
  input wire logic        rx_out_valid,
  input wire logic [31:0] rx_out_hdr,
  input wire logic        rx_out_ecrc_valid,
  input wire logic        rx_out_ready,
  input wire logic        rx_np_hold,
  input wire logic        rx_ecrc_error,
  // Transmit side
  input wire logic        tx_in_valid,
  input wire logic [31:0] tx_in_hdr,
  input wire logic [31:0] tx_in_ecrc,
  input wire logic        tx_in_ready,
  input wire logic        tx_out_valid,
  input wire logic [31:0] tx_out_hdr,
  input wire logic [31:0] tx_out_ecrc,
  // Staging
  input wire logic [1:0]  link_rate,
  input wire logic        core_cfg_over_link
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Shadow of the control register
  logic [3:0] ctrl_q;
  wire        rx_take = rx_in_valid && rx_in_ready;
  wire        tx_take = tx_in_valid && tx_in_ready;
  always @(posedge core_clk) begin
    if (!rst_n) ctrl_q <= 4'h0;
    else if (reg_wr && reg_addr == 8'h00) ctrl_q <= reg_wdata[3:0];
  end
  AST_RX_STALL: assert property (rx_out_valid && !rx_out_ready |=>
    rx_out_valid && $stable(rx_out_hdr)) else $error("rx beat changed while stalled");
  AST_NP_WITHHELD: assert property (rx_np_hold && $past(rx_np_hold) && rx_out_valid
    && rx_out_hdr[1:0] == 2'h1 |-> $past(rx_out_valid && !rx_out_ready))
    else $error("non-posted presented under hold");
  AST_ERR_CAUSE: assert property (rx_ecrc_error |->
    $past(rx_take && rx_in_hdr[3] && ctrl_q[0])) else $error("error without checked digest");
  AST_ERR_PULSE: assert property (rx_ecrc_error |=> !rx_ecrc_error)
    else $error("error pulse too long");
  AST_RX_STRIP: assert property (rx_out_valid && rx_out_ecrc_valid |->
    ctrl_q[2] && rx_out_hdr[3]) else $error("ecrc attached wrongly");
  AST_TX_GEN: assert property (tx_take && !ctrl_q[2] |=> tx_out_valid &&
    tx_out_hdr[3] == ctrl_q[1] && (ctrl_q[1] || tx_out_ecrc == 32'h0))
    else $error("tx digest handling wrong");
  AST_TX_FWD: assert property (tx_take && ctrl_q[2] |=> tx_out_hdr == $past(tx_in_hdr)
    && tx_out_ecrc == $past(tx_in_ecrc)) else $error("forwarded tx changed");
  AST_CFG_RATE: assert property (core_cfg_over_link |-> $past(ctrl_q[3] &&
    (link_rate == 2'h1 || link_rate == 2'h2))) else $error("link config at wrong rate");
  cover property (rx_ecrc_error);
  cover property (core_cfg_over_link);
  cover property (rx_np_hold && rx_out_valid && rx_out_ready);
endmodule
`default_nettype wire

// ---- app_side_model.sv ----
// Application side model: receive sink with stall and non-posted hold
`default_nettype none
module app_side_model (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Receive stream
  input  wire logic        rx_out_valid,
  input  wire logic [31:0] rx_out_hdr,
  input  wire logic [31:0] rx_out_data,
  input  wire logic [31:0] rx_out_ecrc,
  input  wire logic        rx_out_ecrc_valid,
  input  wire logic        rx_ecrc_error,
  output logic             rx_out_ready,
  output logic             rx_np_hold,
  // Bench controls
  input  wire logic        stall,
  input  wire logic        hold_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] hdr_q[$];
  logic [31:0] data_q[$];
  logic [31:0] ecrc_q[$];
  int          n_err = 0;
  always @(posedge core_clk) begin
    rx_out_ready <= rst_n && !stall;
    rx_np_hold <= hold_req;
    if (rx_ecrc_error) n_err <= n_err + 1;
    if (rst_n && rx_out_valid && rx_out_ready) begin
      hdr_q.push_back(rx_out_hdr);
      data_q.push_back(rx_out_data);
      // Forwarded ECRC kept for the application's own check
      ecrc_q.push_back(rx_out_ecrc_valid ? rx_out_ecrc : 32'hffffffff);
    end
  end
endmodule
`default_nettype wire

// ---- test_tlp_ordering_ecrc_path.sv ----
// Self-checking bench for the TLP ordering and ECRC path
`include "tlp_ordering_ecrc_defines.vh"
`default_nettype none
module test_tlp_ordering_ecrc_path;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic rx_in_valid = 1'h0, tx_in_valid = 1'h0, tx_out_ready = 1'h1, stall = 1'h0;
  logic periph_loaded = 1'h0, link_l0 = 1'h0, core_programmed = 1'h0, hold_req = 1'h0;
  logic [1:0] link_rate = 2'h3;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, rx_in_hdr = 32'h0, rx_in_data = 32'h0, rx_in_ecrc = 32'h0;
  logic [31:0] tx_in_hdr = 32'h0, tx_in_data = 32'h0, tx_in_ecrc = 32'h0;
  wire [31:0] reg_rdata, rx_out_hdr, rx_out_data, rx_out_ecrc, tx_out_hdr, tx_out_data;
  wire [31:0] tx_out_ecrc;
  wire rx_in_ready, rx_out_valid, rx_out_ecrc_valid, rx_out_ready, rx_np_hold, rx_ecrc_error;
  wire tx_in_ready, tx_out_valid, core_cfg_over_link, core_ready;
  int n_errors = 0, comparisons = 0;
  always #2 core_clk = ~core_clk;
  tlp_ordering_ecrc_path dut_u (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .rx_in_valid, .rx_in_hdr, .rx_in_data, .rx_in_ecrc, .rx_in_ready, .rx_out_valid,
    .rx_out_hdr, .rx_out_data, .rx_out_ecrc, .rx_out_ecrc_valid, .rx_out_ready, .rx_np_hold,
    .rx_ecrc_error, .tx_in_valid, .tx_in_hdr, .tx_in_data, .tx_in_ecrc, .tx_in_ready,
    .tx_out_valid, .tx_out_hdr, .tx_out_data, .tx_out_ecrc, .tx_out_ready, .periph_loaded,
    .link_l0, .link_rate, .core_programmed, .core_cfg_over_link, .core_ready);
  app_side_model app_u (.core_clk, .rst_n, .rx_out_valid, .rx_out_hdr, .rx_out_data,
    .rx_out_ecrc, .rx_out_ecrc_valid, .rx_ecrc_error, .rx_out_ready, .rx_np_hold, .stall,
    .hold_req);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic [31:0] crc(input logic [31:0] h, input logic [31:0] d);
    logic [63:0] m;
    logic [31:0] c;
    m = {h, d};
    c = `CRC_SEED;
    for (int k = 63; k >= 0; k--) c = {c[30:0], 1'h0} ^ ((c[31] ^ m[k]) ? `CRC_POLY : 32'h0);
    return ~c;
  endfunction
  task automatic do_reset();
    rst_n <= 1'h0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
  endtask
  task automatic send_rx(input logic [31:0] h, input logic [31:0] d, input logic [31:0] c);
    int t = 0;
    @(posedge core_clk);
    rx_in_valid <= 1'h1;
    rx_in_hdr <= h;
    rx_in_data <= d;
    rx_in_ecrc <= c;
    do @(posedge core_clk); while (rx_in_ready !== 1'h1 && ++t < 100);
    rx_in_valid <= 1'h0;
    if (t >= 100) n_errors++;
  endtask
  task automatic send_tx(input logic [31:0] h, input logic [31:0] d, input logic [31:0] c);
    int t = 0;
    @(posedge core_clk);
    tx_in_valid <= 1'h1;
    tx_in_hdr <= h;
    tx_in_data <= d;
    tx_in_ecrc <= c;
    do @(posedge core_clk); while (tx_in_ready !== 1'h1 && ++t < 100);
    tx_in_valid <= 1'h0;
    if (t >= 100) n_errors++;
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    give_verdict();
  end
  initial begin
    logic [31:0] v, h, c, eh, ec;
    logic fwd, chk, drop;
    int n0, e0;
    logic [31:0] ord_h [5] = '{32'h1, 32'h1, 32'h0, 32'h6, 32'h20};
    logic [31:0] ord_x [5] = '{32'h22, 32'h24, 32'h23, 32'h20, 32'h21};
    do_reset();
    reg_read(`REG_CTRL_ADDR, v);
    check(v, 32'h0);
    reg_write(`REG_CTRL_ADDR, 32'hffffffff);
    reg_read(`REG_CTRL_ADDR, v);
    check(v, 32'hf);
    reg_write(`REG_STATUS_ADDR, 32'hffffffff);
    reg_read(8'h0c, v);
    check(v, 32'h0);
    periph_loaded <= 1'h1;
    repeat (4) @(posedge core_clk);
    reg_read(`REG_STATUS_ADDR, v);
    check(v, 32'h4);
    check(core_cfg_over_link, 1'h0);
    $display("test registers and fast rate done");
    periph_loaded <= 1'h0;
    link_rate <= `RATE_GEN2;
    do_reset();
    reg_write(`REG_CTRL_ADDR, 32'h8);
    periph_loaded <= 1'h1;
    repeat (4) @(posedge core_clk);
    reg_read(`REG_STATUS_ADDR, v);
    check(v, 32'h12);
    link_l0 <= 1'h1;
    repeat (4) @(posedge core_clk);
    reg_read(`REG_STATUS_ADDR, v);
    check(v, 32'h14);
    check(core_cfg_over_link, 1'h1);
    core_programmed <= 1'h1;
    repeat (4) @(posedge core_clk);
    check(core_ready, 1'h1);
    $display("test staging done");
    for (int i = 0; i < 12; i++) begin
      fwd = (i >= 6);
      chk = ((i / 3) % 2 == 1);
      h = (i % 3 != 0) ? 32'h8 : 32'h0;
      c = crc(h, i) ^ ((i % 3 == 2) ? 32'h1 : 32'h0);
      drop = chk && (i % 3 == 2);
      reg_write(`REG_CTRL_ADDR, {28'h0, 1'h1, fwd, 1'h0, chk});
      n0 = app_u.hdr_q.size();
      e0 = app_u.n_err;
      send_rx(h, i, c);
      repeat (8) @(posedge core_clk);
      check(app_u.hdr_q.size() - n0, !drop);
      check(app_u.n_err - e0, drop);
      if (!drop) begin
        check(app_u.hdr_q[n0], h);
        check(app_u.ecrc_q[n0], (fwd && h[3]) ? c : 32'hffffffff);
      end
    end
    reg_read(`REG_ERR_COUNT_ADDR, v);
    check(v, 32'h2);
    reg_read(`REG_STATUS_ADDR, v);
    check(v, 32'h38);
    reg_write(`REG_ERR_COUNT_ADDR, 32'h0);
    reg_read(`REG_ERR_COUNT_ADDR, v);
    check(v, 32'h0);
    reg_read(`REG_STATUS_ADDR, v);
    check(v, 32'h18);
    $display("test receive ecrc done");
    reg_write(`REG_CTRL_ADDR, 32'h8);
    n0 = app_u.hdr_q.size();
    stall <= 1'h1;
    hold_req <= 1'h1;
    foreach (ord_h[k]) send_rx(ord_h[k], 32'h20 + k, 32'h0);
    repeat (10) @(posedge core_clk);
    stall <= 1'h0;
    repeat (20) @(posedge core_clk);
    check(app_u.hdr_q.size() - n0, 32'h3);
    hold_req <= 1'h0;
    repeat (20) @(posedge core_clk);
    foreach (ord_x[k]) check(app_u.data_q[n0 + k], ord_x[k]);
    $display("test ordering done");
    for (int i = 0; i < 4; i++) begin
      h = (i % 2 == 0) ? 32'h8 : 32'h0;
      c = h[3] ? 32'h5a5a5a5a : 32'h0;
      reg_write(`REG_CTRL_ADDR, (i >= 2) ? 32'hc : {30'h2, i[0], 1'h0});
      eh = (i >= 2) ? h : (i == 1) ? (h | 32'h8) : (h & ~32'h8);
      ec = (i >= 2) ? c : (i == 1) ? crc(eh, 32'h100 + i) : 32'h0;
      send_tx(h, 32'h100 + i, c);
      #1;
      check(tx_out_valid, 1'h1);
      check(tx_out_hdr, eh);
      check(tx_out_data, 32'h100 + i);
      check(tx_out_ecrc, ec);
    end
    $display("test transmit done");
    give_verdict();
  end
endmodule
bind tlp_ordering_ecrc_path tlp_ordering_ecrc_path_props chk_u (.core_clk, .rst_n, .reg_addr,
  .reg_wdata, .reg_wr, .rx_in_valid, .rx_in_hdr, .rx_in_ready, .rx_out_valid, .rx_out_hdr,
  .rx_out_ecrc_valid, .rx_out_ready, .rx_np_hold, .rx_ecrc_error, .tx_in_valid, .tx_in_hdr,
  .tx_in_ecrc, .tx_in_ready, .tx_out_valid, .tx_out_hdr, .tx_out_ecrc, .link_rate,
  .core_cfg_over_link);
`default_nettype wire
